// ==== ffm_regs.svh ====
`ifndef FFM_REGS_SVH
`define FFM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FFM_ADDR_CONFIG    8'h15
`define FFM_ADDR_SOURCE    8'h16
`define FFM_ADDR_THRESHOLD 8'h17
`define FFM_ADDR_DELAY     8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FFM_CFG_LATCH_BIT  7
`define FFM_CFG_COMB_BIT   6
`define FFM_CFG_EN_LSB     3
`define FFM_CFG_EN_MSB     5
`define FFM_THS_MODE_BIT   7
`define FFM_THS_VAL_MSB    6
`define FFM_SRC_ACTIVE_BIT 7

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define FFM_CONFIG_RESET   8'h00
`define FFM_THS_RESET      8'h00
`define FFM_DELAY_RESET    8'h00
`define FFM_READ_ZERO      8'h00
`define FFM_CONFIG_RESET_BIT_LATCH 1'b0
`define FFM_THS_RESET_BIT_MODE     1'b0

`endif

// ==== ffm_pkg.sv ====
package ffm_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ffm_idle   = 2'b01,
      ffm_active = 2'b10
   } ffm_event_state_type;

   typedef logic [2:0] ffm_axis_vec_type;
   typedef logic [7:0] ffm_byte_type;

endpackage : ffm_pkg

// ==== ffm_axis_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface ffm_axis_if;
   import ffm_pkg::*;
   ffm_axis_vec_type high;
   ffm_axis_vec_type negative;

   modport cmp (output high, output negative);
   modport det (input high, input negative);
endinterface : ffm_axis_if

`default_nettype wire

// ==== ffm_axis_cmp.sv ====
`timescale 1ns/10ps
`default_nettype none

module ffm_axis_cmp #(
   parameter int DATA_W = 12,
   parameter int THS_W  = 7
) (
   input  wire logic [3*DATA_W-1:0] accel_all,
   input  wire logic [THS_W-1:0]    threshold,
   ffm_axis_if.cmp                  axis
);
   import ffm_pkg::*;

   initial begin
      if (DATA_W <= THS_W) begin
         $error("ffm_axis_cmp: DATA_W must exceed THS_W");
      end
   end

   // ----------------------------------------------------------------------
   // Per-axis magnitude against the threshold
   // ----------------------------------------------------------------------
   // Only the top bits of the magnitude are compared, so one threshold
   // step spans 2**(DATA_W-THS_W-1) sample codes.
   for (genvar i = 0; i < 3; i++) begin : g_axis
      logic [DATA_W-1:0] sample;
      logic [DATA_W-1:0] mag;
      assign sample = accel_all[i*DATA_W +: DATA_W];
      assign mag    = sample[DATA_W-1] ?
                      (~sample + {{(DATA_W-1){1'b0}}, 1'b1}) : sample;
      assign axis.high[i]     = mag[DATA_W-1 -: THS_W+1] >
                                {1'b0, threshold};  // RULE15
      assign axis.negative[i] = sample[DATA_W-1];
   end

endmodule : ffm_axis_cmp

`default_nettype wire

// ==== ffm_debounce.sv ====
`timescale 1ns/10ps
`default_nettype none

module ffm_debounce #(
   parameter int CNT_W = 8
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             step,
   input  wire logic             cond,
   input  wire logic             clear_mode,
   input  wire logic [CNT_W-1:0] delay,
   input  wire logic             clear,
   output logic      [CNT_W-1:0] count,
   output logic      [CNT_W-1:0] next_count
);

   initial begin
      if (CNT_W < 1) begin
         $error("ffm_debounce: CNT_W must be at least 1");
      end
   end

   // ----------------------------------------------------------------------
   // Next count
   // ----------------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (step) begin  // RULE21
         if (cond) begin
            if (count >= delay) begin
               next_count = delay;  // RULE20
            end else begin
               next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end else if (clear_mode) begin
            next_count = '0;  // RULE18
         end else if (count != '0) begin
            next_count = count - {{(CNT_W-1){1'b0}}, 1'b1};  // RULE17
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule : ffm_debounce

`default_nettype wire

// ==== ffm_detector.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ffm_regs.svh"

// Notes on behaviour
// RULE1: Latched freefall: active flag sets at full count, holds until source read.
// RULE2: Latched freefall: source read clears active flag and counter.
// RULE3: Only enabled axes enter the combined condition.
// RULE4: Axis flags follow raw comparison live, unless latched and active.
// RULE5: Latched freefall: axis flags freeze on activation, resume after read.
// RULE6: Motion, decrement mode: active flag clears once counter is back at zero.
// RULE7: Motion, clear mode: active flag drops when condition goes false.
// RULE8: Non-latched motion: source read has no side effect.
// RULE9: Latched motion: source read clears all source bits and counter.
// RULE10: Latched motion: axis flags hold captured values until read.
// RULE11: Config bit 7 selects latched flags; resets to zero.
// RULE12: Config bit 6 selects AND freefall or OR motion; resets to zero.
// RULE13: Config bits 5..3 enable Z, Y, X; bits 2..0 read zero.
// RULE14: Freefall: every enabled axis magnitude at or below threshold.
// RULE15: Motion: any enabled axis magnitude strictly above threshold.
// RULE16: Source register read-only: active, zero, then Z, Y, X flag pairs.
// RULE17: Decrement mode: counter drops by one per false sample, floor zero.
// RULE18: Clear mode: counter goes to zero on a false sample.
// RULE19: Event flag sets when counter reaches programmed count.
// RULE20: Counter saturates at the programmed count.
// RULE21: Counter steps at most once per new sample.
// RULE22: Source read returns pre-clear contents; clearing follows capture.
module ffm_detector
   import ffm_pkg::*;
#(
   parameter int DATA_W = 12,
   parameter int THS_W  = 7,
   parameter int CNT_W  = 8
) (
   input  wire logic                core_clk,
   input  wire logic                reset_n,
   input  wire logic                sample_valid,
   input  wire logic [DATA_W-1:0]   accel_x,
   input  wire logic [DATA_W-1:0]   accel_y,
   input  wire logic [DATA_W-1:0]   accel_z,
   input  wire logic [7:0]          reg_addr,
   input  wire logic                reg_wr_en,
   input  wire ffm_pkg::ffm_byte_type reg_wr_data,
   input  wire logic                reg_rd_en,
   output ffm_pkg::ffm_byte_type    reg_rd_data,
   output logic                     reg_rd_valid,
   output logic                     event_active
);
   import ffm_pkg::*;

   initial begin
      if (THS_W != 7) begin
         $error("ffm_detector: threshold field is seven bits wide");
      end
      if (CNT_W != 8) begin
         $error("ffm_detector: delay register is eight bits wide");
      end
      if (DATA_W <= THS_W) begin
         $error("ffm_detector: DATA_W must exceed THS_W");
      end
   end

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] addr,
                                    input logic [7:0] target);
      addr_is = (addr == target);
   endfunction : addr_is

   // Interleaves axis event and polarity flags into Z, Y, X pairs.
   function automatic logic [5:0] pack_flags(input ffm_axis_vec_type evt,
                                             input ffm_axis_vec_type pol);
      pack_flags = {evt[2], pol[2], evt[1], pol[1], evt[0], pol[0]};
   endfunction : pack_flags

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic                latch_enable;
   logic                combine_select;
   ffm_axis_vec_type    axis_enable;
   logic                debounce_mode;
   logic [THS_W-1:0]    event_threshold;
   logic [CNT_W-1:0]    debounce_delay;

   logic                wr_config;
   logic                wr_threshold;
   logic                wr_delay;
   logic                src_read;

   assign wr_config    = reg_wr_en && addr_is(reg_addr, `FFM_ADDR_CONFIG);
   assign wr_threshold = reg_wr_en && addr_is(reg_addr, `FFM_ADDR_THRESHOLD);
   assign wr_delay     = reg_wr_en && addr_is(reg_addr, `FFM_ADDR_DELAY);
   assign src_read     = reg_rd_en && addr_is(reg_addr, `FFM_ADDR_SOURCE);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_enable   <= `FFM_CONFIG_RESET_BIT_LATCH;  // RULE11
         combine_select <= 1'b0;  // RULE12
         axis_enable    <= 3'h0;  // RULE13
      end else if (wr_config) begin
         latch_enable   <= reg_wr_data[`FFM_CFG_LATCH_BIT];  // RULE11
         combine_select <= reg_wr_data[`FFM_CFG_COMB_BIT];  // RULE12
         axis_enable    <= reg_wr_data[`FFM_CFG_EN_MSB:`FFM_CFG_EN_LSB];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         debounce_mode   <= `FFM_THS_RESET_BIT_MODE;
         event_threshold <= 7'h00;
      end else if (wr_threshold) begin
         debounce_mode   <= reg_wr_data[`FFM_THS_MODE_BIT];
         event_threshold <= reg_wr_data[`FFM_THS_VAL_MSB:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         debounce_delay <= `FFM_DELAY_RESET;
      end else if (wr_delay) begin
         debounce_delay <= reg_wr_data;
      end
   end

   // ----------------------------------------------------------------------
   // Axis comparison
   // ----------------------------------------------------------------------
   ffm_axis_if axis_res ();

   ffm_axis_cmp #(
      .DATA_W (DATA_W),
      .THS_W  (THS_W)
   ) u_cmp (
      .accel_all (
         {accel_z, accel_y, accel_x}),
      .threshold (event_threshold),
      .axis      (axis_res.cmp)
   );

   // ----------------------------------------------------------------------
   // Combined condition
   // ----------------------------------------------------------------------
   // With no axis enabled the function is off, so freefall never holds
   // vacuously on an empty set of axes.
   logic             cond_freefall;
   logic             cond_motion;
   logic             cond;
   ffm_axis_vec_type live_evt;
   ffm_axis_vec_type live_pol;

   assign cond_freefall = (axis_enable != 3'h0) &&
                          ((axis_res.high & axis_enable) == 3'h0);  // RULE14
   assign cond_motion   = |(axis_res.high & axis_enable);  // RULE3 RULE15
   assign cond          = combine_select ? cond_motion : cond_freefall;

   assign live_evt = axis_res.high & axis_enable;  // RULE3
   assign live_pol = axis_res.negative & axis_res.high & axis_enable;

   // ----------------------------------------------------------------------
   // Debounce counter
   // ----------------------------------------------------------------------
   logic             latched_clear;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   // Only the latched modes give the source read a side effect.
   assign latched_clear = latch_enable && src_read;  // RULE2 RULE8 RULE9

   ffm_debounce #(
      .CNT_W (CNT_W)
   ) u_debounce (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .step       (sample_valid),
      .cond       (cond),
      .clear_mode (debounce_mode),
      .delay      (debounce_delay),
      .clear      (latched_clear),
      .count      (count),
      .next_count (next_count)
   );

   // ----------------------------------------------------------------------
   // Event state
   // ----------------------------------------------------------------------
   // A sample that would complete the count in the very cycle of a clearing
   // read raises no event unless the delay is zero: the clear wins over the step.
   ffm_event_state_type state;
   ffm_event_state_type next_state;
   logic                ev_set;
   logic                ev_drop;

   assign ev_set  = sample_valid && cond &&
                    (next_count == debounce_delay);  // RULE19 RULE1
   assign ev_drop = latch_enable ? src_read :
                    (sample_valid && !cond &&
                     (next_count == '0));  // RULE6 RULE7

   always_comb begin
      next_state = state;
      case (state)
         ffm_idle: begin
            if (ev_set) begin
               next_state = ffm_active;
            end
         end
         ffm_active: begin
            if (ev_drop && !ev_set) begin
               next_state = ffm_idle;  // RULE2 RULE9
            end
         end
         default: begin
            next_state = ffm_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ffm_idle;
      end else begin
         state <= next_state;
      end
   end

   assign event_active = (state == ffm_active);

   // ----------------------------------------------------------------------
   // Axis flags
   // ----------------------------------------------------------------------
   // Flags take the sample that raises the event, then freeze while
   // latched; in real-time modes they follow every sample.
   ffm_axis_vec_type flag_evt;
   ffm_axis_vec_type flag_pol;
   logic             frozen;

   assign frozen = latch_enable && (state == ffm_active);  // RULE5 RULE10

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_evt <= 3'h0;
         flag_pol <= 3'h0;
      end else if (latched_clear) begin
         flag_evt <= sample_valid ? live_evt : 3'h0;  // RULE9
         flag_pol <= sample_valid ? live_pol : 3'h0;
      end else if (sample_valid && !frozen) begin
         flag_evt <= live_evt;  // RULE4
         flag_pol <= live_pol;
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Read data is captured from the flops before this edge, so a
   // clearing read still returns what was latched.
   ffm_byte_type source_value;
   ffm_byte_type config_value;
   ffm_byte_type read_mux;

   assign source_value = {event_active, 1'b0,
                          pack_flags(flag_evt & axis_enable,
                                     flag_pol & axis_enable)};  // RULE16
   assign config_value = {latch_enable, combine_select, axis_enable,
                          3'h0};  // RULE13

   always_comb begin
      read_mux = `FFM_READ_ZERO;
      case (reg_addr)
         `FFM_ADDR_CONFIG: begin
            read_mux = config_value;
         end
         `FFM_ADDR_SOURCE: begin
            read_mux = source_value;
         end
         `FFM_ADDR_THRESHOLD: begin
            read_mux = {debounce_mode, event_threshold};
         end
         `FFM_ADDR_DELAY: begin
            read_mux = debounce_delay;
         end
         default: begin
            read_mux = `FFM_READ_ZERO;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rd_data <= `FFM_READ_ZERO;
      end else if (reg_rd_en) begin
         reg_rd_data <= read_mux;  // RULE22
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
      end
   end

endmodule : ffm_detector

`default_nettype wire

// ==== ffm_detector_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ffm_regs.svh"

module ffm_detector_monitor (
   input wire logic                  core_clk,
   input wire logic                  reset_n,
   input wire logic                  sample_valid,
   input wire logic [7:0]            reg_addr,
   input wire logic                  reg_wr_en,
   input wire ffm_pkg::ffm_byte_type reg_wr_data,
   input wire logic                  reg_rd_en,
   input wire ffm_pkg::ffm_byte_type reg_rd_data,
   input wire logic                  reg_rd_valid,
   input wire logic                  event_active
);
   import ffm_pkg::*;

   logic       latch;
   logic [2:0] axis_en;
   logic [7:0] rd_addr;
   logic       src_rd;

   assign src_rd = reg_rd_en && (reg_addr == `FFM_ADDR_SOURCE);

   // ---------------------------------------------------------------
   // Shadow state
   // ---------------------------------------------------------------
   // Mode bits are mirrored so each check knows which clear rule holds
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         latch   <= 1'b0;
         axis_en <= 3'h0;
      end else if (reg_wr_en && reg_addr == `FFM_ADDR_CONFIG) begin
         latch   <= reg_wr_data[7];
         axis_en <= reg_wr_data[5:3];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_addr <= 8'h00;
      end else if (reg_rd_en) begin
         rd_addr <= reg_addr;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   rd_latency_a: assert property (
      reg_rd_en |=> reg_rd_valid) else $error("read answer missing");
   rd_single_a: assert property (
      !reg_rd_en |=> !reg_rd_valid) else $error("read answer unasked");
   set_by_sample_a: assert property (
      $rose(event_active) |-> $past(sample_valid))
      else $error("event set without sample");
   step_per_sample_a: assert property (
      $changed(event_active) |->
         $past(sample_valid) || $past(reg_rd_en) || $past(reg_wr_en))
      else $error("event moved without cause");
   latched_hold_a: assert property (
      latch && event_active && !src_rd && !reg_wr_en |=> event_active)
      else $error("latched event dropped");
   read_clears_a: assert property (
      latch && src_rd && !sample_valid && !reg_wr_en |=> !event_active)
      else $error("latched event not cleared by read");
   read_no_effect_a: assert property (
      !latch && src_rd && !sample_valid && !reg_wr_en
         |=> $stable(event_active)) else $error("read changed event");
   src_layout_a: assert property (
      reg_rd_valid && rd_addr == `FFM_ADDR_SOURCE |->
         reg_rd_data[7] == $past(event_active) && !reg_rd_data[6])
      else $error("source byte layout wrong");
   axis_masked_a: assert property (
      reg_rd_valid && rd_addr == `FFM_ADDR_SOURCE |->
         (reg_rd_data[5:0] & ~{{2{$past(axis_en[2])}},
            {2{$past(axis_en[1])}}, {2{$past(axis_en[0])}}}) == 6'h00)
      else $error("disabled axis flag set");
   cfg_low_zero_a: assert property (
      reg_rd_valid && rd_addr == `FFM_ADDR_CONFIG |->
         reg_rd_data[2:0] == 3'h0) else $error("config low bits set");

endmodule : ffm_detector_monitor

bind ffm_detector ffm_detector_monitor mon_u (
   .core_clk     (core_clk),
   .reset_n      (reset_n),
   .sample_valid (sample_valid),
   .reg_addr     (reg_addr),
   .reg_wr_en    (reg_wr_en),
   .reg_wr_data  (reg_wr_data),
   .reg_rd_en    (reg_rd_en),
   .reg_rd_data  (reg_rd_data),
   .reg_rd_valid (reg_rd_valid),
   .event_active (event_active)
);

`default_nettype wire

// ==== ffm_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module ffm_host_model (
   input  wire logic                  core_clk,
   output logic [7:0]                 reg_addr,
   output logic                       reg_wr_en,
   output ffm_pkg::ffm_byte_type      reg_wr_data,
   output logic                       reg_rd_en,
   input  wire ffm_pkg::ffm_byte_type reg_rd_data,
   input  wire logic                  reg_rd_valid
);
   import ffm_pkg::*;

   initial begin
      reg_addr    = 8'h00;
      reg_wr_en   = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en   = 1'b0;
   end

   // Released lines show the inverse so stale values never look valid
   task automatic wr(input logic [7:0] a, input ffm_byte_type d);
      @(posedge core_clk);
      reg_addr    <= a;
      reg_wr_data <= d;
      reg_wr_en   <= 1'b1;
      @(posedge core_clk);
      reg_wr_en   <= 1'b0;
      reg_addr    <= ~a;
      reg_wr_data <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output ffm_byte_type d);
      int n;
      @(posedge core_clk);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      reg_addr  <= ~a;
      n = 0;
      #1;
      // Answer is taken once settled, in the cycle it stands
      while (!reg_rd_valid && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      // A missing answer returns unknown so the compare counts it
      d = reg_rd_valid ? reg_rd_data : 8'hxx;
   endtask : rd

endmodule : ffm_host_model

`default_nettype wire

// ==== test_freefall_motion_event_detector.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ffm_regs.svh"

module test_freefall_motion_event_detector;
   import ffm_pkg::*;

   localparam logic [11:0] HI   = 12'h200;
   localparam logic [11:0] NEG  = 12'he00;
   localparam logic [11:0] LOW  = 12'h010;
   localparam logic [11:0] EDGE = 12'h0a0;
   localparam logic [11:0] N16  = 12'hf00;

   logic         core_clk;
   logic         reset_n;
   logic         sample_valid;
   logic [11:0]  accel_x;
   logic [11:0]  accel_y;
   logic [11:0]  accel_z;
   logic [7:0]   reg_addr;
   logic         reg_wr_en;
   logic         reg_rd_en;
   logic         reg_rd_valid;
   logic         event_active;
   ffm_byte_type reg_wr_data;
   ffm_byte_type reg_rd_data;
   ffm_byte_type rdat;
   int           err_total;
   int           n_tests;

   ffm_detector dut_u (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .sample_valid (sample_valid),
      .accel_x      (accel_x),
      .accel_y      (accel_y),
      .accel_z      (accel_z),
      .reg_addr     (reg_addr),
      .reg_wr_en    (reg_wr_en),
      .reg_wr_data  (reg_wr_data),
      .reg_rd_en    (reg_rd_en),
      .reg_rd_data  (reg_rd_data),
      .reg_rd_valid (reg_rd_valid),
      .event_active (event_active)
   );

   ffm_host_model host_u (
      .core_clk     (core_clk),
      .reg_addr     (reg_addr),
      .reg_wr_en    (reg_wr_en),
      .reg_wr_data  (reg_wr_data),
      .reg_rd_en    (reg_rd_en),
      .reg_rd_data  (reg_rd_data),
      .reg_rd_valid (reg_rd_valid)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic print_verdict;
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // One sample, then let the update edge land before anything looks
   task automatic smp(input logic [11:0] x, y, z);
      @(posedge core_clk);
      sample_valid <= 1'b1;
      accel_x      <= x;
      accel_y      <= y;
      accel_z      <= z;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      #1;
   endtask : smp

   task automatic rs(input string name, input ffm_byte_type exp);
      host_u.rd(`FFM_ADDR_SOURCE, rdat);
      check(name, rdat, exp);
   endtask : rs

   task automatic ev(input string name, input logic e);
      check(name, {7'h0, event_active}, {7'h0, e});
   endtask : ev

   task automatic cfg(input ffm_byte_type c, t, d);
      host_u.wr(`FFM_ADDR_CONFIG, c);
      host_u.wr(`FFM_ADDR_THRESHOLD, t);
      host_u.wr(`FFM_ADDR_DELAY, d);
   endtask : cfg

   initial begin
      repeat (20000) @(posedge core_clk);
      err_total++;
      print_verdict();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      err_total    = 0;
      n_tests      = 0;
      reset_n      = 1'b0;
      sample_valid = 1'b0;
      accel_x      = 12'h000;
      accel_y      = 12'h000;
      accel_z      = 12'h000;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      host_u.rd(`FFM_ADDR_CONFIG, rdat);
      check("config reset", rdat, 8'h00);
      rs("source reset", 8'h00);
      host_u.wr(`FFM_ADDR_CONFIG, 8'hff);
      host_u.rd(`FFM_ADDR_CONFIG, rdat);
      check("config rw", rdat, 8'hf8);
      host_u.wr(`FFM_ADDR_SOURCE, 8'h7f);
      rs("source ro", 8'h00);
      // Real-time motion, decrementing count that saturates at 2
      cfg(8'h48, 8'h0a, 8'h02);
      smp(HI, 12'h000, 12'h000);
      ev("nl first", 1'b0);
      repeat (3) smp(HI, 12'h000, 12'h000);
      ev("nl set", 1'b1);
      rs("nl live", 8'h82);
      ev("nl read", 1'b1);
      smp(LOW, HI, NEG);
      ev("nl decr one", 1'b1);
      rs("nl masked", 8'h80);
      smp(LOW, 12'h000, 12'h000);
      ev("nl decr two", 1'b0);
      // Real-time motion, count cleared on a false sample
      cfg(8'h48, 8'h8a, 8'h02);
      repeat (2) smp(HI, 12'h000, 12'h000);
      ev("cm set", 1'b1);
      smp(LOW, 12'h000, 12'h000);
      ev("cm drop", 1'b0);
      smp(HI, 12'h000, 12'h000);
      ev("cm restart", 1'b0);
      rs("cm live", 8'h02);
      // Latched motion on all axes
      cfg(8'hf8, 8'h8a, 8'h03);
      smp(12'h000, 12'h000, 12'h000);
      repeat (2) smp(HI, 12'h000, 12'h000);
      ev("lm not yet", 1'b0);
      smp(HI, 12'h000, 12'h000);
      ev("lm set", 1'b1);
      smp(12'h000, 12'h000, NEG);
      rs("lm frozen", 8'h82);
      ev("lm cleared", 1'b0);
      rs("lm bits cleared", 8'h00);
      smp(12'h000, 12'h000, NEG);
      rs("lm live", 8'h30);
      repeat (2) smp(12'h000, 12'h000, NEG);
      ev("lm rearm", 1'b0);
      smp(12'h000, 12'h000, NEG);
      ev("lm rearmed", 1'b1);
      rs("lm z", 8'hb0);
      // Latched freefall on X only, magnitude at the threshold
      cfg(8'h88, 8'h0a, 8'h02);
      smp(EDGE, HI, NEG);
      ev("ff first", 1'b0);
      smp(EDGE, HI, NEG);
      ev("ff set", 1'b1);
      smp(N16, 12'h000, 12'h000);
      ev("ff held", 1'b1);
      rs("ff frozen", 8'h80);
      ev("ff cleared", 1'b0);
      smp(EDGE, 12'h000, 12'h000);
      ev("ff rearm", 1'b0);
      smp(N16, 12'h000, 12'h000);
      rs("ff resume", 8'h03);
      print_verdict();
   end

endmodule : test_freefall_motion_event_detector

`default_nettype wire
